// ### common/pdmi_pkg.sv
// Purpose: Shared constants and types for the parity DRAM module controller
// Assumes: 25 MHz core clock (40 ns period)
// Notes:   Cycle counts derive from printed times; least times round up
package pdmi_pkg;

    localparam int          CLK_NS            = 40;
    // Widths of the module's pins and its row count
    localparam int          ADDR_W            = 10;
    localparam int          DATA_W            = 8;
    localparam int          ROW_W             = 10;
    localparam int          ROW_COUNT         = 1024;
    // Printed times and the init row strobe count
    localparam int          POWERUP_US        = 200;
    localparam int          REFRESH_MS        = 16;
    localparam int          RC_MIN_NS         = 130;
    localparam int          RAS_MIN_NS        = 70;
    localparam int          RAS_MAX_NS        = 10000;
    localparam int          RP_MIN_NS         = 50;
    localparam int          CSR_MIN_NS        = 10;
    localparam int          CHR_MIN_NS        = 20;
    localparam int          CAS_MIN_NS        = 20;
    localparam int          RCD_MIN_NS        = 20;
    localparam int          INIT_RAS_CYCLES   = 8;
    // Least times round up to whole cycles, none below one
    function automatic int up_cyc(input int ns);
        int c;
        c = (ns + CLK_NS - 1) / CLK_NS;
        return (c < 1) ? 1 : c;
    endfunction : up_cyc
    localparam int          RAS_CYC           = up_cyc(RAS_MIN_NS);
    localparam int          RP_CYC            = up_cyc(RP_MIN_NS);
    localparam int          CSR_CYC           = up_cyc(CSR_MIN_NS);
    localparam int          CHR_CYC           = up_cyc(CHR_MIN_NS);
    localparam int          CAS_CYC           = up_cyc(CAS_MIN_NS);
    localparam int          RCD_CYC           = up_cyc(RCD_MIN_NS);
    localparam int          RAS_MAX_CYC       = RAS_MAX_NS / CLK_NS;
    // Long counts: defaults for top-level parameters
    localparam int          POWERUP_CYC       = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    localparam int          REFRESH_INT_CYC   = (REFRESH_MS * 1000000 / ROW_COUNT) / CLK_NS;
    localparam logic [3:0]  TIMER_RST         = 4'h0;

    typedef enum logic [3:0] {
        PDMI_POWERUP  = 4'h0,
        PDMI_INIT_LO  = 4'h1,
        PDMI_INIT_HI  = 4'h2,
        PDMI_IDLE     = 4'h3,
        PDMI_ROW      = 4'h4,
        PDMI_COL      = 4'h5,
        PDMI_CAS      = 4'h6,
        PDMI_PRECH    = 4'h7,
        PDMI_CBR_CAS  = 4'h8,
        PDMI_CBR_RAS  = 4'h9
    } pdmi_state_t;

endpackage : pdmi_pkg

// ### rtl/pdmi_cnt.sv
// Purpose: Loadable down counter with done flag
// Assumes: Synchronous active-high reset
// Notes:   Used for the power-up pause; the refresh interval has its own divider
`timescale 1ns/1ps
module pdmi_cnt #(
    parameter int W = 24
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] value_i,
    output logic              done_o
);
    logic [W-1:0] cnt_r;

    // Count to zero, then hold until reloaded
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            cnt_r <= '0;
        else if (load_i)
            cnt_r <= value_i;
        else if (cnt_r != '0)
            cnt_r <= cnt_r - 1'b1;
    end

    assign done_o = (cnt_r == '0) && !load_i;
endmodule : pdmi_cnt

// ### rtl/pdmi_ctrl.sv
// Purpose: Controller driving a 1M x 9 parity DRAM module
// Assumes: One request at a time; pins sampled synchronous to core_clk_i
// Notes:   No page mode; every access is a single random cycle
// Behaviour
// - Pause, then eight row strobes before use
// - Refresh all 1024 rows every 16 ms
// - Write line inactive through read cycle end
// - Page row pulse bounded, column cycle timed
// - Column strobe leads and trails row strobe
// - Write line inactive around refresh row edge
// - Counter test column high at least 35 ns
// - Cycle at least 130 ns, pulse 70-10000 ns
`timescale 1ns/1ps
module pdmi_ctrl
    import pdmi_pkg::*;
#(
    parameter int POWERUP_CYCLES = pdmi_pkg::POWERUP_CYC,
    parameter int REFRESH_CYCLES = pdmi_pkg::REFRESH_INT_CYC
) (
    input  wire logic                       core_clk_i,
    input  wire logic                       rst_i,
    input  wire logic                       req_valid_i,
    input  wire logic                       req_write_i,
    input  wire logic [2*pdmi_pkg::ADDR_W-1:0] req_addr_i,
    input  wire logic [pdmi_pkg::DATA_W-1:0] req_wdata_i,
    input  wire logic                       req_wpar_i,
    output logic                            req_ready_o,
    output logic                            rsp_valid_o,
    output logic [pdmi_pkg::DATA_W-1:0]     rsp_rdata_o,
    output logic                            rsp_rpar_o,
    output logic                            init_done_o,
    output logic [pdmi_pkg::ADDR_W-1:0]     mem_addr_o,
    output logic                            row_strobe_n_o,
    output logic                            column_strobe_n_o,
    output logic                            parity_column_strobe_n_o,
    output logic                            write_n_o,
    output logic [pdmi_pkg::DATA_W-1:0]     mem_dq_o,
    output logic                            mem_dq_oe_o,
    input  wire logic [pdmi_pkg::DATA_W-1:0] mem_dq_i,
    output logic                            parity_data_in_o,
    input  wire logic                       parity_data_out_i
);
    import pdmi_pkg::*;

    pdmi_state_t               state_r;
    logic [3:0]                tmr_r;
    logic [3:0]                init_cnt_r;
    logic                      wr_r;
    logic [2*ADDR_W-1:0]       addr_r;
    logic                      ref_pend_r;
    logic                      pu_done;
    logic                      ref_tick;
    logic                      pu_load_r;

    // Power-up pause timer, loaded once after reset
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            pu_load_r <= 1'b1;
        else
            pu_load_r <= 1'b0;
    end

    pdmi_cnt #(.W(24)) u_pu_cnt (
        .core_clk_i (core_clk_i),
        .rst_i      (rst_i),
        .load_i     (pu_load_r),
        .value_i    (24'(POWERUP_CYCLES)),
        .done_o     (pu_done)
    );

    logic ref_zero_r;
    logic [23:0] ref_div_r;
    // Refresh interval: one row every 16 ms / 1024, reloads itself
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i || ref_div_r == 24'h000000)
            ref_div_r <= 24'(REFRESH_CYCLES - 1);
        else
            ref_div_r <= ref_div_r - 24'h000001;
    end
    assign ref_tick = (ref_div_r == 24'h000000);

    // Pending refresh request; a new tick wins over the clear
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            ref_zero_r <= 1'b0;
        else
            ref_zero_r <= ref_tick;
    end
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
            ref_pend_r <= 1'b0;
        else if (ref_zero_r)
            ref_pend_r <= 1'b1;
        else if (state_r == PDMI_CBR_CAS)
            ref_pend_r <= 1'b0;
    end

    // Main sequencer and pin drive
    always_ff @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            state_r                  <= PDMI_POWERUP;
            tmr_r                    <= TIMER_RST;
            init_cnt_r               <= 4'h0;
            wr_r                     <= 1'b0;
            addr_r                   <= '0;
            row_strobe_n_o           <= 1'b1;
            column_strobe_n_o        <= 1'b1;
            parity_column_strobe_n_o <= 1'b1;
            write_n_o                <= 1'b1;
            mem_addr_o               <= '0;
            mem_dq_o                 <= '0;
            mem_dq_oe_o              <= 1'b0;
            parity_data_in_o         <= 1'b0;
            req_ready_o              <= 1'b0;
            rsp_valid_o              <= 1'b0;
            rsp_rdata_o              <= '0;
            rsp_rpar_o               <= 1'b0;
            init_done_o              <= 1'b0;
        end
        else
        begin
            rsp_valid_o <= 1'b0;
            if (tmr_r != 4'h0)
                tmr_r <= tmr_r - 4'h1;
            case (state_r)
                PDMI_POWERUP:
                begin
                    if (pu_done && !pu_load_r)
                    begin
                        row_strobe_n_o <= 1'b0;
                        tmr_r          <= 4'(RAS_CYC - 1);
                        state_r        <= PDMI_INIT_LO;
                    end
                end
                PDMI_INIT_LO:
                begin
                    if (tmr_r == 4'h0)
                    begin
                        row_strobe_n_o <= 1'b1;
                        tmr_r          <= 4'(RP_CYC - 1);
                        init_cnt_r     <= init_cnt_r + 4'h1;
                        state_r        <= PDMI_INIT_HI;
                    end
                end
                PDMI_INIT_HI:
                begin
                    if (tmr_r == 4'h0)
                    begin
                        if (init_cnt_r == 4'(INIT_RAS_CYCLES))
                        begin
                            init_done_o <= 1'b1;
                            req_ready_o <= 1'b1;
                            state_r     <= PDMI_IDLE;
                        end
                        else
                        begin
                            row_strobe_n_o <= 1'b0;
                            tmr_r          <= 4'(RAS_CYC - 1);
                            state_r        <= PDMI_INIT_LO;
                        end
                    end
                end
                PDMI_IDLE:
                begin
                    if (ref_pend_r)
                    begin
                        // Column-before-row refresh; module supplies the row
                        req_ready_o              <= 1'b0;
                        column_strobe_n_o        <= 1'b0;
                        parity_column_strobe_n_o <= 1'b0;
                        write_n_o                <= 1'b1;
                        tmr_r                    <= 4'(CSR_CYC - 1);
                        state_r                  <= PDMI_CBR_CAS;
                    end
                    else if (req_valid_i)
                    begin
                        // Row address first
                        req_ready_o <= 1'b0;
                        wr_r        <= req_write_i;
                        addr_r      <= req_addr_i;
                        mem_addr_o  <= req_addr_i[2*ADDR_W-1:ADDR_W];
                        mem_dq_o    <= req_wdata_i;
                        parity_data_in_o <= req_wpar_i;
                        state_r     <= PDMI_ROW;
                    end
                end
                PDMI_ROW:
                begin
                    row_strobe_n_o <= 1'b0;
                    tmr_r          <= 4'(RCD_CYC);      // Column address gets a full cycle of setup
                    state_r        <= PDMI_COL;
                end
                PDMI_COL:
                begin
                    // Early write: write line low a cycle before column strobe
                    mem_addr_o  <= addr_r[ADDR_W-1:0];
                    write_n_o   <= !wr_r;
                    mem_dq_oe_o <= wr_r;
                    if (tmr_r == 4'h0)
                    begin
                        column_strobe_n_o        <= 1'b0;
                        parity_column_strobe_n_o <= 1'b0;
                        tmr_r                    <= 4'(CAS_CYC);
                        state_r                  <= PDMI_CAS;
                    end
                end
                PDMI_CAS:
                begin
                    // Extra cycle covers column access plus sampling margin
                    if (tmr_r == 4'h0)
                    begin
                        rsp_rdata_o              <= mem_dq_i;
                        rsp_rpar_o               <= parity_data_out_i;
                        rsp_valid_o              <= 1'b1;
                        row_strobe_n_o           <= 1'b1;               // One column per row
                        column_strobe_n_o        <= 1'b1;
                        parity_column_strobe_n_o <= 1'b1;
                        tmr_r                    <= 4'(RP_CYC - 1);
                        state_r                  <= PDMI_PRECH;
                    end
                end
                PDMI_PRECH:
                begin
                    // Write line released only after both strobes rose
                    write_n_o   <= 1'b1;
                    mem_dq_oe_o <= 1'b0;
                    if (tmr_r == 4'h0)
                    begin
                        req_ready_o <= 1'b1;
                        state_r     <= PDMI_IDLE;
                    end
                end
                PDMI_CBR_CAS:
                begin
                    if (tmr_r == 4'h0)
                    begin
                        row_strobe_n_o <= 1'b0;
                        tmr_r          <= 4'(RAS_CYC - 1);
                        state_r        <= PDMI_CBR_RAS;
                    end
                end
                PDMI_CBR_RAS:
                begin
                    if (tmr_r == 4'h0)
                    begin
                        row_strobe_n_o           <= 1'b1;
                        column_strobe_n_o        <= 1'b1;               // Never re-lowered here
                        parity_column_strobe_n_o <= 1'b1;
                        tmr_r                    <= 4'(RP_CYC - 1);
                        state_r                  <= PDMI_PRECH;
                    end
                end
                default:
                    state_r <= PDMI_IDLE;
            endcase
        end
    end

    // Checks on the pins this controller drives and on its sequencer
    row_first_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(row_strobe_n_o) && state_r == PDMI_CBR_RAS |-> !column_strobe_n_o && $past(!column_strobe_n_o))
        else $error("refresh column strobe not leading row strobe");
    cbr_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        state_r == PDMI_CBR_RAS |-> write_n_o)
        else $error("write line active during refresh");
    read_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(row_strobe_n_o) && state_r == PDMI_PRECH && $past(write_n_o) |-> write_n_o)
        else $error("write line active at read end");
    early_write_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(column_strobe_n_o) && !mem_dq_oe_o |-> write_n_o)
        else $error("write line low without data drive");
    ras_width_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $fell(row_strobe_n_o) |=> !row_strobe_n_o [*1])
        else $error("row strobe pulse too short");
    parity_strobe_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        parity_column_strobe_n_o == column_strobe_n_o)
        else $error("parity strobe differs from column strobe");
    init_count_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        $rose(init_done_o) |-> init_cnt_r == 4'(INIT_RAS_CYCLES))
        else $error("ready before eight init cycles");
    refresh_take_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
        ref_pend_r && state_r == PDMI_IDLE |=> state_r == PDMI_CBR_CAS)
        else $error("pending refresh not started");
endmodule : pdmi_ctrl

// ### tb/parity_dram_module_interface_test.sv
// Purpose: Self-checking bench for the parity DRAM module controller
// Assumes: Inputs change at falling clock edges
// Notes:   Short pause and refresh counts keep the run brief
`timescale 1ns/1ps
module parity_dram_module_interface_test;
    import pdmi_pkg::*;

    localparam int PWR_CYC = 20;
    localparam int REF_CYC = 40;

    logic                core_clk_i;
    logic                rst_i;
    logic                req_valid_i;
    logic                req_write_i;
    logic [2*ADDR_W-1:0] req_addr_i;
    logic [DATA_W-1:0]   req_wdata_i;
    logic                req_wpar_i;
    logic                req_ready_o;
    logic                rsp_valid_o;
    logic [DATA_W-1:0]   rsp_rdata_o;
    logic                rsp_rpar_o;
    logic                init_done_o;
    logic [ADDR_W-1:0]   mem_addr_o;
    logic                row_strobe_n_o;
    logic                column_strobe_n_o;
    logic                parity_column_strobe_n_o;
    logic                write_n_o;
    logic [DATA_W-1:0]   mem_dq_o;
    logic                mem_dq_oe_o;
    logic [DATA_W-1:0]   mem_dq_i;
    logic                parity_data_in_o;
    logic                parity_data_out_i;
    int                  ras_cnt;
    int                  cbr_cnt;
    int                  failures = 0;
    int                  checked  = 0;
    int                  low_n, high_n, gap;
    int                  acc_n = 0;
    int                  wlow  = 0;
    logic                row_q, col_q, cbr, chr;

    pdmi_ctrl #(.POWERUP_CYCLES(PWR_CYC), .REFRESH_CYCLES(REF_CYC)) i_dut (
        .core_clk_i, .rst_i, .req_valid_i, .req_write_i, .req_addr_i, .req_wdata_i, .req_wpar_i,
        .req_ready_o, .rsp_valid_o, .rsp_rdata_o, .rsp_rpar_o, .init_done_o, .mem_addr_o,
        .row_strobe_n_o, .column_strobe_n_o, .parity_column_strobe_n_o, .write_n_o,
        .mem_dq_o, .mem_dq_oe_o, .mem_dq_i, .parity_data_in_o, .parity_data_out_i
    );

    pdmi_mem_model i_mem (
        .addr_i(mem_addr_o), .row_n_i(row_strobe_n_o), .col_n_i(column_strobe_n_o),
        .pcol_n_i(parity_column_strobe_n_o), .write_n_i(write_n_o), .dq_i(mem_dq_o),
        .par_in_i(parity_data_in_o), .dq_o(mem_dq_i), .par_out_o(parity_data_out_i),
        .ras_cnt_o(ras_cnt), .cbr_cnt_o(cbr_cnt)
    );

    initial
    begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end

    task automatic end_of_test;
        if (failures == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : end_of_test

    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    task automatic give_up(input string what);
        failures++;
        $display("MISMATCH %s expected done seen timeout", what);
        end_of_test();
    endtask : give_up

    // Pin watch; sees pre-edge values of the registered pins
    always @(posedge core_clk_i)
    begin
        if (rst_i)
        begin
            {low_n, high_n, gap} = '0;
            {row_q, col_q, cbr, chr} = 4'hE;
        end
        else
        begin
            gap = init_done_o ? gap + 1 : 0;
            if (chr)
                check("refresh column hold", 0, column_strobe_n_o);
            chr = 1'b0;
            if (row_q && !row_strobe_n_o)
            begin
                check("row precharge", 1, high_n >= RP_CYC);
                high_n = 0;
                cbr = !column_strobe_n_o;
                if (cbr)
                begin
                    check("refresh column lead", 0, col_q);
                    check("refresh write line", 1, write_n_o);
                    check("refresh gap", 1, gap <= REF_CYC + 16);
                    gap = 0;
                    chr = 1'b1;
                end
                else
                    acc_n++;
            end
            if (!row_q && row_strobe_n_o)
            begin
                check("row pulse", 1, low_n >= RAS_CYC && low_n <= RAS_MAX_CYC);
                low_n = 0;
            end
            // Data must be driven exactly when the column edge writes
            if (!row_strobe_n_o && col_q && !column_strobe_n_o && !cbr)
                check("data drive", !write_n_o, mem_dq_oe_o);
            // A refresh row must not see a second column strobe
            if (!row_strobe_n_o && col_q && !column_strobe_n_o && cbr)
                check("refresh column reentry", 0, cbr);
            if (row_strobe_n_o)
                high_n++;
            else
                low_n++;
            if (!row_strobe_n_o && !write_n_o)
                wlow++;
            row_q = row_strobe_n_o;
            col_q = column_strobe_n_o;
        end
    end

    task automatic init_seq;
        int n;
        check("ready in reset", 0, req_ready_o);
        rst_i = 1'b0;
        repeat (PWR_CYC - 1) @(negedge core_clk_i);
        check("row strobes during pause", 0, ras_cnt);
        for (n = 0; n < 400 && init_done_o !== 1'b1; n++)
            @(negedge core_clk_i);
        if (init_done_o !== 1'b1)
            give_up("init");
        check("init row strobes", 8, ras_cnt);
        check("init refreshes", 0, cbr_cnt);
        check("ready after init", 1, req_ready_o);
    endtask : init_seq

    // Holds the request until a row cycle with column high starts
    task automatic access(input logic wr, input logic [19:0] a, input logic [8:0] d, output logic [8:0] q);
        int n;
        int a0;
        int w0;
        a0 = acc_n;
        req_valid_i = 1'b1;
        req_write_i = wr;
        req_addr_i = a;
        {req_wpar_i, req_wdata_i} = d;
        for (n = 0; n < 200 && acc_n == a0; n++)
            @(negedge core_clk_i);
        if (acc_n == a0)
            give_up("take");
        req_valid_i = 1'b0;
        w0 = wlow;
        for (n = 0; n < 200 && rsp_valid_o !== 1'b1; n++)
            @(negedge core_clk_i);
        if (rsp_valid_o !== 1'b1)
            give_up("answer");
        q = {rsp_rpar_o, rsp_rdata_o};
        if (!wr)
            check("read write line", w0, wlow);
    endtask : access

    // Corner addresses, both parity values, back to back across refreshes
    task automatic data_scenario;
        logic [19:0] adr [4];
        logic [8:0]  dat [4];
        logic [8:0]  q;
        adr = '{20'h00000, 20'hFFFFF, 20'h5A3C1, 20'h003FF};
        dat = '{9'h1A5, 9'h03C, 9'h1FF, 9'h100};
        for (int i = 0; i < 4; i++)
            access(1'b1, adr[i], dat[i], q);
        for (int i = 0; i < 4; i++)
        begin
            access(1'b0, adr[i], 9'h000, q);
            check("read word", dat[i], q);
        end
    endtask : data_scenario

    task automatic refresh_scenario;
        int c0;
        c0 = cbr_cnt;
        repeat (8 * REF_CYC) @(negedge core_clk_i);
        check("refresh count", 1, cbr_cnt - c0 >= 7);
    endtask : refresh_scenario

    initial
    begin
        rst_i = 1'b1;
        {req_valid_i, req_write_i, req_wpar_i} = 3'h0;
        req_addr_i = 20'h00000;
        req_wdata_i = 8'h00;
        repeat (16) @(negedge core_clk_i);
        init_seq();
        data_scenario();
        refresh_scenario();
        data_scenario();
        end_of_test();
    end
endmodule : parity_dram_module_interface_test

// ### tb/pdmi_mem_model.sv
// Purpose: Behavioural 1M x 9 parity DRAM module at the controller pins
// Assumes: Strobes and write line active low; no clock of its own
// Notes:   Released outputs show the inverse of the last value
`timescale 1ns/1ps
module pdmi_mem_model
    import pdmi_pkg::*;
#(
    parameter int ACCESS_NS = 15
) (
    input  wire logic [pdmi_pkg::ADDR_W-1:0] addr_i,
    input  wire logic                        row_n_i,
    input  wire logic                        col_n_i,
    input  wire logic                        pcol_n_i,
    input  wire logic                        write_n_i,
    input  wire logic [pdmi_pkg::DATA_W-1:0] dq_i,
    input  wire logic                        par_in_i,
    output logic      [pdmi_pkg::DATA_W-1:0] dq_o,
    output logic                             par_out_o,
    output int                               ras_cnt_o,
    output int                               cbr_cnt_o
);
    logic [ROW_W-1:0]  row  = '0;
    logic [ADDR_W-1:0] col  = '0;
    logic [ROW_W-1:0]  rcnt = '0;
    logic              cbr  = 1'b0;
    logic [7:0]        mem_d [int];
    logic              mem_p [int];

    function automatic int key(input logic [ADDR_W-1:0] a);
        return int'({row, a});
    endfunction : key

    initial
    begin
        dq_o      = 8'h00;
        par_out_o = 1'b0;
        ras_cnt_o = 0;
        cbr_cnt_o = 0;
    end

    // Row edge; a leading column strobe means refresh from the counter
    always @(negedge row_n_i)
    begin
        ras_cnt_o++;
        cbr = !col_n_i || !pcol_n_i;
        row = cbr ? rcnt : addr_i;
        rcnt = cbr ? rcnt + 10'h001 : rcnt;
        cbr_cnt_o = cbr ? cbr_cnt_o + 1 : cbr_cnt_o;
    end

    // Column fall: early write stores and leaves outputs as they are, else read after access
    always @(negedge col_n_i)
    begin
        col = addr_i;
        if (!row_n_i && !write_n_i)
            mem_d[key(addr_i)] = dq_i;
        else if (!row_n_i)
            dq_o <= #(ACCESS_NS) mem_d.exists(key(addr_i)) ? mem_d[key(addr_i)] : ~addr_i[7:0];
    end

    // Parity bit has its own strobe and pins
    always @(negedge pcol_n_i)
    begin
        col = addr_i;
        if (!row_n_i && !write_n_i)
            mem_p[key(addr_i)] = par_in_i;
        else if (!row_n_i)
            par_out_o <= #(ACCESS_NS) mem_p.exists(key(addr_i)) ? mem_p[key(addr_i)] : ^addr_i;
    end

    // Late write line edge captures data in read-write cycles
    always @(negedge write_n_i)
    begin
        if (!row_n_i && !col_n_i)
            mem_d[key(col)] = dq_i;
        if (!row_n_i && !pcol_n_i)
            mem_p[key(col)] = par_in_i;
    end

    // Release flips outputs so a stale value never passes for data
    always @(posedge col_n_i)
        dq_o <= #5 ~dq_o;
    always @(posedge pcol_n_i)
        par_out_o <= #5 ~par_out_o;
endmodule : pdmi_mem_model
